// >>> design/phc_control.sv
`timescale 1ns/1ps
// What this block does
// - a low level arriving on the handler start line is taken as a request to run a task.
// - from a start until the task ends the busy flag is pulled low as an open-drain output.
// - a failed task pulls the fail flag low as an open-drain output.
// - holding the button for two seconds in operation mode enters selection mode.
// - each short press in selection mode steps the operation to the next, wrapping round.
// - holding the button for three seconds in selection mode returns to operation mode.
// - selection mode with no button activity for the idle interval returns to operation mode.
// - button selection and button start work only in stand-alone, but a press held as stand-alone ends, short of a long hold, counts as a short press.
// - the yellow indicator is lit while a task is in progress.
// - the green indicator is lit when a task ends with a correct result.
// - the red indicator is lit when a task ends with an incorrect result.
module phc_control
  import phc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P    = phc_pkg::TICK_CYCLES,
  parameter int unsigned ENTER_TICKS_P    = phc_pkg::ENTER_HOLD_TICKS,
  parameter int unsigned LEAVE_TICKS_P    = phc_pkg::LEAVE_HOLD_TICKS,
  parameter int unsigned IDLE_TICKS_P     = phc_pkg::IDLE_TICKS,
  parameter int unsigned DEBOUNCE_TICKS_P = phc_pkg::DEBOUNCE_TICKS,
  parameter int unsigned NUM_OPS_P        = phc_pkg::NUM_OPS,
  parameter int unsigned OP_W_P           = phc_pkg::OP_W
) (
  // clock and reset
  input  wire logic              clock_in,
  input  wire logic              reset_in,
  // handler connector: start request, active low
  input  wire logic              start_n_in,
  // handler connector: open-drain result lines
  input  wire logic              busy_flag_in,
  output logic                   busy_flag_out,
  output logic                   busy_flag_oe_out,
  input  wire logic              pass_flag_in,
  output logic                   pass_flag_out,
  output logic                   pass_flag_oe_out,
  input  wire logic              fail_flag_in,
  output logic                   fail_flag_out,
  output logic                   fail_flag_oe_out,
  // front panel
  input  wire logic              button_n_in,
  input  wire logic              standalone_in,
  output logic                   select_mode_out,
  output logic [OP_W_P-1:0]      op_sel_out,
  output logic                   led_busy_out,
  output logic                   led_ok_out,
  output logic                   led_fail_out,
  // programming engine
  output logic                   task_start_out,
  input  wire logic              task_done_in,
  input  wire logic              task_ok_in
);
  import phc_pkg::*;

  localparam int unsigned DIV_W = $clog2(TICK_CYCLES_P + 1);
  localparam int unsigned HW    = 16;

  // ---------------------------------------------------------------
  // millisecond enable from a divider
  // ---------------------------------------------------------------
  logic [DIV_W-1:0] div_cnt;
  logic             tick;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end else begin
      tick    <= (div_cnt == DIV_W'(TICK_CYCLES_P - 1));
      div_cnt <= (div_cnt == DIV_W'(TICK_CYCLES_P - 1)) ? '0 : div_cnt + DIV_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // input conditioning
  // ---------------------------------------------------------------
  logic [1:0] clean;
  logic       start_prev;
  logic       button_prev;
  logic       pressed;     // filtered button, gated off under host operation

  phc_debounce #(
    .N            (2),
    .STABLE_TICKS (DEBOUNCE_TICKS_P),
    .RESET_LEVEL  (LINE_IDLE_LEVEL)
  ) u_debounce (
    .clock_in  (clock_in),
    .reset_in  (reset_in),
    .tick_in   (tick),
    .raw_in    ({button_n_in, start_n_in}),
    .clean_out (clean)
  );

  // edge history of the filtered lines
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      start_prev  <= LINE_IDLE_LEVEL;
      button_prev <= 1'b0;
    end else begin
      start_prev  <= clean[0];
      button_prev <= pressed;
    end
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  phc_task_state_t     task_st;
  phc_task_state_t     next_task;
  phc_mode_t           mode;
  phc_mode_t           next_mode;
  logic                result_ok;
  logic [HW-1:0]       held_cnt;
  logic [HW-1:0]       idle_cnt;
  logic                consumed;

  // ---------------------------------------------------------------
  // decode of button and start events
  // ---------------------------------------------------------------
  assign pressed          = ~clean[1] & standalone_in;
  wire logic released     = button_prev & ~pressed;
  wire logic short_press  = released & ~consumed;
  wire logic start_req    = start_prev & ~clean[0];
  wire logic task_free    = (task_st == T_IDLE) | (task_st == T_RESULT);
  wire logic in_select    = (mode == M_SELECT);
  wire logic enter_hit    = ~in_select & pressed & ~consumed & tick &
                            (held_cnt == HW'(ENTER_TICKS_P - 1));
  wire logic leave_hit    = in_select & pressed & ~consumed & tick &
                            (held_cnt == HW'(LEAVE_TICKS_P - 1));
  wire logic idle_hit     = in_select & ~pressed & ~released & tick &
                            (idle_cnt == HW'(IDLE_TICKS_P - 1));
  wire logic step_op      = in_select & short_press;
  wire logic button_start = ~in_select & short_press;
  // a start only counts while no task runs; others are dropped
  wire logic go           = (start_req | button_start) & task_free;
  wire logic [OP_W_P-1:0] op_next =
    (op_sel_out == OP_W_P'(NUM_OPS_P - 1)) ? '0 : op_sel_out + OP_W_P'(1);

  // ---------------------------------------------------------------
  // next states
  // ---------------------------------------------------------------
  always_comb begin
    next_task = task_st;
    unique case (task_st)
      T_IDLE, T_RESULT: if (go) next_task = T_BUSY;
      T_BUSY:           if (task_done_in) next_task = T_GAP;
      T_GAP:            next_task = T_RESULT;
      default:          next_task = T_IDLE;
    endcase
  end

  // leaving on host operation stops the panel and keeps the selection, bar one step from a press held across it short of a long hold
  always_comb begin
    next_mode = mode;
    unique case (mode)
      M_OPERATE: if (enter_hit) next_mode = M_SELECT;
      M_SELECT:  if (leave_hit | idle_hit | ~standalone_in) next_mode = M_OPERATE;
      default:   next_mode = M_OPERATE;
    endcase
  end

  // ---------------------------------------------------------------
  // task sequencing and handler flags
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      task_st          <= T_IDLE;
      result_ok        <= 1'b0;
      task_start_out   <= 1'b0;
      busy_flag_oe_out <= 1'b0;
      pass_flag_oe_out <= 1'b0;
      fail_flag_oe_out <= 1'b0;
    end else begin
      task_st          <= next_task;
      task_start_out   <= go;
      if (task_st == T_BUSY && task_done_in) begin
        result_ok <= task_ok_in;
      end
      busy_flag_oe_out <= (next_task == T_BUSY);
      pass_flag_oe_out <= (next_task == T_RESULT) & result_ok;
      fail_flag_oe_out <= (next_task == T_RESULT) & ~result_ok;
    end
  end

  // open-drain lines only ever pull low; the level flops never move
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      busy_flag_out <= DRIVE_LEVEL;
      pass_flag_out <= DRIVE_LEVEL;
      fail_flag_out <= DRIVE_LEVEL;
    end else begin
      busy_flag_out <= DRIVE_LEVEL;
      pass_flag_out <= DRIVE_LEVEL;
      fail_flag_out <= DRIVE_LEVEL;
    end
  end

  // indicators follow the same decisions as the handler flags
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      led_busy_out <= 1'b0;
      led_ok_out   <= 1'b0;
      led_fail_out <= 1'b0;
    end else begin
      led_busy_out <= (next_task == T_BUSY);
      led_ok_out   <= (next_task == T_RESULT) & result_ok;
      led_fail_out <= (next_task == T_RESULT) & ~result_ok;
    end
  end

  // ---------------------------------------------------------------
  // front panel mode, hold timing and selection
  // ---------------------------------------------------------------
  // consumed stops the release after a long hold being read as a step
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      mode            <= M_OPERATE;
      select_mode_out <= 1'b0;
      op_sel_out      <= '0;
      held_cnt        <= '0;
      idle_cnt        <= '0;
      consumed        <= 1'b0;
    end else begin
      mode            <= next_mode;
      select_mode_out <= (next_mode == M_SELECT);
      if (step_op) begin
        op_sel_out <= op_next;
      end
      if (!pressed) begin
        held_cnt <= '0;
      end else if (tick && held_cnt != '1) begin
        held_cnt <= held_cnt + HW'(1);
      end
      if (!pressed) begin
        consumed <= 1'b0;
      end else if (enter_hit || leave_hit) begin
        consumed <= 1'b1;
      end
      if (!in_select || pressed || released) begin
        idle_cnt <= '0;
      end else if (tick) begin
        idle_cnt <= idle_cnt + HW'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  sequence s_busy_end;
    busy_flag_oe_out ##1 !busy_flag_oe_out;
  endsequence

  sequence s_one_result;
    (pass_flag_oe_out ^ fail_flag_oe_out);
  endsequence

  start_to_busy_a: assert property (go |=> busy_flag_oe_out && task_start_out)
    else $error("busy flag not pulled after start");
  result_gap_a: assert property (s_busy_end |->
                                 !pass_flag_oe_out && !fail_flag_oe_out ##1 s_one_result)
    else $error("result flag not one cycle after busy release");
  fail_drive_a: assert property (task_st == T_BUSY && task_done_in && !task_ok_in
                                 |=> ##1 fail_flag_oe_out && led_fail_out)
    else $error("fail flag missing after failed task");
  pass_drive_a: assert property (task_st == T_BUSY && task_done_in && task_ok_in
                                 |=> ##1 pass_flag_oe_out && led_ok_out)
    else $error("pass flag missing after good task");
  result_hold_a: assert property (pass_flag_oe_out && !go |=> pass_flag_oe_out)
    else $error("pass flag dropped before next start");
  busy_ignore_a: assert property (busy_flag_oe_out && start_req |=> !task_start_out)
    else $error("start taken while busy");
  enter_select_a: assert property (enter_hit |=> select_mode_out)
    else $error("long hold did not enter selection");
  step_op_a: assert property (step_op && !reset_in |=> op_sel_out != $past(op_sel_out))
    else $error("short press did not step operation");
  leave_keep_a: assert property (leave_hit |=> !select_mode_out && $stable(op_sel_out))
    else $error("leave hold did not return with selection kept");
  idle_leave_a: assert property (idle_hit |=> !select_mode_out)
    else $error("selection did not time out");
  host_panel_a: assert property (!standalone_in |=> !select_mode_out && !button_start)
    else $error("panel active outside stand-alone");
  busy_led_a: assert property (busy_flag_oe_out |-> led_busy_out)
    else $error("busy indicator off during task");

  // results, indicators and stepping as the handler and the user see them
  fail_hold_a: assert property (fail_flag_oe_out && !go |=> fail_flag_oe_out)
    else $error("fail flag dropped before next start");
  busy_excl_a: assert property (busy_flag_oe_out
                                |-> !pass_flag_oe_out && !fail_flag_oe_out)
    else $error("result flag shown while busy");
  start_take_a: assert property (start_req && task_free |=> busy_flag_oe_out)
    else $error("free start request not taken");
  button_go_a: assert property (button_start && task_free |=> led_busy_out)
    else $error("button start did not light busy");
  ok_only_a: assert property (led_ok_out |-> !led_fail_out && !led_busy_out)
    else $error("ok indicator lit with another");
  led_fail_a: assert property (task_st == T_RESULT && !result_ok |-> led_fail_out)
    else $error("fail indicator off after failed task");
  op_hold_a: assert property (!step_op |=> $stable(op_sel_out))
    else $error("operation moved without a step");

endmodule : phc_control

// >>> design/phc_pkg.sv
package phc_pkg;

  // ---------------------------------------------------------------
  // clock and time base
  // ---------------------------------------------------------------
  localparam int unsigned CLOCK_HZ        = 100_000_000;
  localparam int unsigned TICK_TIME_US    = 1000;
  localparam int unsigned TICK_CYCLES     = CLOCK_HZ / 1_000_000 * TICK_TIME_US;
  localparam int unsigned TICK_MS         = TICK_TIME_US / 1000;

  // ---------------------------------------------------------------
  // button and input timing, in milliseconds and in ticks
  // ---------------------------------------------------------------
  localparam int unsigned ENTER_HOLD_MS    = 2000;
  localparam int unsigned LEAVE_HOLD_MS    = 3000;
  localparam int unsigned IDLE_TIMEOUT_MS  = 10000;
  localparam int unsigned DEBOUNCE_MS      = 10;
  localparam int unsigned ENTER_HOLD_TICKS = ENTER_HOLD_MS / TICK_MS;
  localparam int unsigned LEAVE_HOLD_TICKS = LEAVE_HOLD_MS / TICK_MS;
  localparam int unsigned IDLE_TICKS       = IDLE_TIMEOUT_MS / TICK_MS;
  localparam int unsigned DEBOUNCE_TICKS   = DEBOUNCE_MS / TICK_MS;

  // ---------------------------------------------------------------
  // operations and reset values
  // ---------------------------------------------------------------
  localparam int unsigned NUM_OPS         = 4;
  localparam int unsigned OP_W            = 2;
  localparam logic        LINE_IDLE_LEVEL = 1'b1;
  localparam logic        DRIVE_LEVEL     = 1'b0;

  // task sequencing states
  typedef enum logic [3:0] {
    T_IDLE   = 4'b0001,
    T_BUSY   = 4'b0010,
    T_GAP    = 4'b0100,
    T_RESULT = 4'b1000
  } phc_task_state_t;

  // front panel modes
  typedef enum logic [1:0] {
    M_OPERATE = 2'b01,
    M_SELECT  = 2'b10
  } phc_mode_t;

endpackage : phc_pkg

// >>> design/phc_debounce.sv
`timescale 1ns/1ps
module phc_debounce #(
  parameter int unsigned N            = 2,
  parameter int unsigned STABLE_TICKS = 10,
  parameter logic        RESET_LEVEL  = 1'b1
) (
  // clock and reset
  input  wire logic         clock_in,
  input  wire logic         reset_in,
  // time base
  input  wire logic         tick_in,
  // raw and filtered levels
  input  wire logic [N-1:0] raw_in,
  output logic      [N-1:0] clean_out
);
  localparam int unsigned CW = $clog2(STABLE_TICKS + 1);

  // ---------------------------------------------------------------
  // one synchroniser and stability filter per line
  // ---------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_line
    logic          sync_a;
    logic          sync_b;
    logic [CW-1:0] stable_cnt;
    // first stage feeds only the second; the filter looks at sync_b
    always_ff @(posedge clock_in) begin
      if (reset_in) begin
        sync_a     <= RESET_LEVEL;
        sync_b     <= RESET_LEVEL;
        clean_out[i] <= RESET_LEVEL;
        stable_cnt <= '0;
      end else begin
        sync_a <= raw_in[i];
        sync_b <= sync_a;
        if (sync_b == clean_out[i]) begin
          stable_cnt <= '0;
        end else if (tick_in) begin
          if (stable_cnt == CW'(STABLE_TICKS - 1)) begin
            clean_out[i] <= sync_b;
            stable_cnt   <= '0;
          end else begin
            stable_cnt <= stable_cnt + CW'(1);
          end
        end
      end
    end
  end

endmodule : phc_debounce

// >>> verification/phc_handler_model.sv
`timescale 1ns/1ps
// handler on the connector plus a stand-in programming engine
module phc_handler_model
  import phc_pkg::*;
(
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       reset_in,
  // bench control
  input  wire logic       start_req_in,
  input  wire logic       ok_cfg_in,
  input  wire logic [7:0] delay_in,
  // from the writer
  input  wire logic       task_start_in,
  input  wire logic       busy_oe_in,
  input  wire logic       pass_oe_in,
  input  wire logic       fail_oe_in,
  // to the writer
  output logic            start_n_out,
  output logic            task_done_out,
  output logic            task_ok_out,
  output logic            busy_line_out,
  output logic            pass_line_out,
  output logic            fail_line_out
);
  logic [7:0] count;
  logic       pending;

  // handler pulls start low to ask for a task
  assign start_n_out = ~start_req_in;
  // pull-ups win whenever the writer lets go
  assign busy_line_out = busy_oe_in ? DRIVE_LEVEL : LINE_IDLE_LEVEL;
  assign pass_line_out = pass_oe_in ? DRIVE_LEVEL : LINE_IDLE_LEVEL;
  assign fail_line_out = fail_oe_in ? DRIVE_LEVEL : LINE_IDLE_LEVEL;
  // result is only valid with done; flip it otherwise so stale reads show
  assign task_ok_out = task_done_out ? ok_cfg_in : ~ok_cfg_in;

  // engine answers after a programmable delay
  always_ff @(posedge clock_in) begin
    task_done_out <= 1'b0;
    if (reset_in) begin
      pending <= 1'b0;
      count   <= 8'h00;
    end else if (task_start_in) begin
      pending <= 1'b1;
      count   <= delay_in;
    end else if (pending && count == 8'h00) begin
      pending       <= 1'b0;
      task_done_out <= 1'b1;
    end else begin
      count <= count - 8'h01;
    end
  end
endmodule : phc_handler_model

// >>> verification/tb_programmer_handler_control.sv
`timescale 1ns/1ps
module tb_programmer_handler_control;
  import phc_pkg::*;
  logic clock_in, reset_in, req, ok_cfg, button_n, standalone;
  logic [7:0] delay;
  logic start_n, done, ok, busy_l, pass_l, fail_l;
  logic busy_oe, pass_oe, fail_oe, busy_o, pass_o, fail_o;
  logic sel, led_b, led_o, led_f, tstart;
  logic [1:0] op;
  int mismatches, checks, starts;
  // ok, engine delay, expected {pass_oe, led_ok, pass line, fail_oe, led_fail, fail line}
  logic [14:0] rows [4] = '{{1'b1, 8'h03, 6'h31}, {1'b0, 8'h00, 6'h0e},
                            {1'b1, 8'h14, 6'h31}, {1'b0, 8'h05, 6'h0e}};

  phc_control #(.TICK_CYCLES_P(10), .DEBOUNCE_TICKS_P(2), .ENTER_TICKS_P(5),
    .LEAVE_TICKS_P(7), .IDLE_TICKS_P(20)) i_dut (
    .clock_in(clock_in), .reset_in(reset_in), .start_n_in(start_n),
    .busy_flag_in(busy_l), .busy_flag_out(busy_o), .busy_flag_oe_out(busy_oe),
    .pass_flag_in(pass_l), .pass_flag_out(pass_o), .pass_flag_oe_out(pass_oe),
    .fail_flag_in(fail_l), .fail_flag_out(fail_o), .fail_flag_oe_out(fail_oe),
    .button_n_in(button_n), .standalone_in(standalone), .select_mode_out(sel),
    .op_sel_out(op), .led_busy_out(led_b), .led_ok_out(led_o), .led_fail_out(led_f),
    .task_start_out(tstart), .task_done_in(done), .task_ok_in(ok));

  phc_handler_model i_handler (
    .clock_in(clock_in), .reset_in(reset_in), .start_req_in(req), .ok_cfg_in(ok_cfg),
    .delay_in(delay), .task_start_in(tstart), .busy_oe_in(busy_oe),
    .pass_oe_in(pass_oe), .fail_oe_in(fail_oe), .start_n_out(start_n),
    .task_done_out(done), .task_ok_out(ok), .busy_line_out(busy_l),
    .pass_line_out(pass_l), .fail_line_out(fail_l));

  // ---------------------------------------------------------------
  // clock, helpers
  // ---------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  always @(posedge clock_in) if (tstart === 1'b1) starts++;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : step

  // waits for the busy level, sampled after each edge has settled
  task automatic wait_busy(input logic lvl);
    int i;
    for (i = 0; i < 400 && busy_oe !== lvl; i++) step(1);
    check(busy_oe, lvl);
  endtask : wait_busy

  task automatic press(input int n);
    @(posedge clock_in) button_n <= 1'b0;
    repeat (n) @(posedge clock_in);
    button_n <= 1'b1;
    step(50);
  endtask : press

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  // watchdog: the whole sequence needs well under 6000 cycles
  initial begin
    repeat (20000) @(posedge clock_in);
    mismatches++;
    print_verdict();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int r, k;
    reset_in = 1'b1; req = 1'b0; ok_cfg = 1'b1; delay = 8'h03;
    button_n = 1'b1; standalone = 1'b1;
    mismatches = 0; checks = 0; starts = 0;
    step(1);
    @(posedge clock_in) reset_in <= 1'b0;
    step(1);
    check({busy_oe, pass_oe, fail_oe, sel, tstart}, 8'h00);
    check({busy_o, pass_o, fail_o, op}, 8'h00);
    check({busy_l, pass_l, fail_l}, 8'h07);
    step(30);
    // handler tasks, one row each: busy, gap, exactly one result held
    for (r = 0; r < 4; r++) begin
      @(posedge clock_in) begin
        ok_cfg <= rows[r][14];
        delay  <= rows[r][13:6];
        req    <= 1'b1;
      end
      wait_busy(1'b1);
      check({tstart, led_b, busy_l, pass_oe, fail_oe}, 8'h18);
      step(1);
      check(tstart, 8'h00);
      @(posedge clock_in) req <= 1'b0;
      wait_busy(1'b0);
      check({pass_oe, fail_oe, busy_l}, 8'h01);
      step(1);
      check({pass_oe, led_o, pass_l, fail_oe, led_f, fail_l}, rows[r][5:0]);
      step(50);
      check({pass_oe, fail_oe}, rows[r][14] ? 8'h02 : 8'h01);
    end
    // a second start while busy is dropped: only the first one is counted
    k = starts;
    @(posedge clock_in) begin
      ok_cfg <= 1'b1;
      delay  <= 8'hc8;
      req    <= 1'b1;
    end
    wait_busy(1'b1);
    @(posedge clock_in) req <= 1'b0;
    step(40);
    @(posedge clock_in) req <= 1'b1;
    step(60);
    check(starts - k, 8'h01);
    @(posedge clock_in) req <= 1'b0;
    wait_busy(1'b0);
    step(40);
    // a button glitch shorter than one tick can never pass the filter
    k = starts;
    press(8);
    check(starts - k, 8'h00);
    // short press in operation mode starts a task
    @(posedge clock_in) delay <= 8'h0a;
    press(40);
    check(starts - k, 8'h01);
    wait_busy(1'b0);
    step(20);
    // long hold enters selection, short presses step and wrap
    press(100);
    check({sel, op}, 8'h04);
    for (r = 1; r <= 5; r++) begin
      press(40);
      check({sel, op}, 8'h04 | (r % NUM_OPS));
    end
    press(130);
    check({sel, op}, 8'h01);
    // selection left alone times out
    press(100);
    check(sel, 8'h01);
    step(100);
    check(sel, 8'h01);
    step(200);
    check({sel, op}, 8'h01);
    // host operation disables the panel
    @(posedge clock_in) standalone <= 1'b0;
    k = starts;
    press(40);
    press(100);
    check({sel, starts[3:0] - k[3:0]}, 8'h00);
    // a mid-run reset drops the held pass result and the selection
    @(posedge clock_in) reset_in <= 1'b1;
    step(2);
    check({busy_oe, pass_oe, fail_oe, led_b, led_o, led_f, sel}, 8'h00);
    check(op, 8'h00);
    @(posedge clock_in) reset_in <= 1'b0;
    step(30);
    check({busy_oe, pass_oe, fail_oe, tstart, starts[3:0] - k[3:0]}, 8'h00);
    print_verdict();
  end
endmodule : tb_programmer_handler_control
